//--- hw/ordc_defs.svh
`ifndef ORDC_DEFS_SVH
`define ORDC_DEFS_SVH

// register offsets
`define ORDC_OFF_INT_LOW 8'h16
`define ORDC_OFF_INT_MID 8'h17
`define ORDC_OFF_INT_HIGH 8'h18
`define ORDC_OFF_FRAC_LOW 8'h19
`define ORDC_OFF_FRAC_MA 8'h1a
`define ORDC_OFF_FRAC_MB 8'h1b
`define ORDC_OFF_FRAC_HIGH 8'h1c
`define ORDC_OFF_DIV_SEL 8'h1d
`define ORDC_OFF_STATUS 8'h30

// reset values
`define ORDC_RST_INT_LOW 8'h40
`define ORDC_RST_INT_MID 8'h00
`define ORDC_RST_INT_HIGH 8'h00
`define ORDC_RST_FRAC_LOW 8'h72
`define ORDC_RST_FRAC_MA 8'hb7
`define ORDC_RST_FRAC_MB 8'hce
`define ORDC_RST_FRAC_HIGH 8'h2b
`define ORDC_RST_DIV_SEL 8'h00

// field layout
`define ORDC_DIV_FIELD_W 2
`define ORDC_STAT_MASTER_BIT 0
`define ORDC_STAT_STROBE_BIT 1

// clock period in ns
`define ORDC_CLK_PERIOD_NS 25

`endif

//--- hw/ordc_pkg.sv
`default_nettype none

package ordc_pkg;

    // per-channel rate divider code, codes follow declaration order
    typedef enum logic [1:0] {
        ORDC_DIV_1,
        ORDC_DIV_2,
        ORDC_DIV_4,
        ORDC_DIV_8
    } ordc_div_t;

endpackage : ordc_pkg

`default_nettype wire

//--- hw/ordc_div_if.sv
`default_nettype none

interface ordc_div_if;
    import ordc_pkg::*;
    logic tick; // base strobe event, one cycle
    ordc_div_t sel; // channel divider code
    logic strobe; // divided channel strobe

    modport ctl (output tick, output sel, input strobe);
    modport div (input tick, input sel, output strobe);
endinterface : ordc_div_if

`default_nettype wire

//--- hw/ordc_chan_div.sv
`default_nettype none

module ordc_chan_div
    import ordc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // divider link
    ordc_div_if.div bus
);

    logic [2:0] cnt_r; // base ticks seen
    logic strobe_r; // divided pulse
    logic [2:0] mask_w; // low count bits that must be zero
    logic fire_w; // this tick is passed on

    // /1 passes every tick, /8 one in eight
    assign mask_w = (bus.sel == ORDC_DIV_1) ? 3'h0 :
                    (bus.sel == ORDC_DIV_2) ? 3'h1 :
                    (bus.sel == ORDC_DIV_4) ? 3'h3 : 3'h7;
    assign fire_w = bus.tick && ((cnt_r & mask_w) == 3'h0);
    assign bus.strobe = strobe_r;

    // count ticks, changing code mid-count just rephases
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 3'h0;
            strobe_r <= 1'b0;
        end else begin
            strobe_r <= fire_w;
            if (bus.tick) begin
                cnt_r <= cnt_r + 3'h1;
            end
        end
    end

    AST_DIV_FULL_RATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        bus.tick && bus.sel == ORDC_DIV_1 |=> strobe_r)
        else $error("full rate channel missed a tick");

    AST_DIV_EIGHTH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        bus.tick && bus.sel == ORDC_DIV_8 && cnt_r != 3'h0 |=> !strobe_r)
        else $error("eighth rate channel fired off phase");

endmodule : ordc_chan_div

`default_nettype wire

//--- hw/ordc_top.sv
`include "ordc_defs.svh"
`default_nettype none

module ordc_top
    import ordc_pkg::*;
#(
    parameter int NUM_CH = 4 // channels with own divider
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // timing role pin, high for master
    input wire logic master_mode_i,
    // output rate strobe pin, two-way
    input wire logic output_rate_strobe_i,
    output logic output_rate_strobe_o,
    output logic output_rate_strobe_oe_o,
    // divided per-channel strobes
    output logic [NUM_CH-1:0] ch_strobe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // register bank

    localparam int NUM_REG = 8; // 0x16 .. 0x1d

    logic [7:0] cfg_r [NUM_REG]; // config bytes, index from 0x16
    logic [7:0] idx_w; // register index
    logic hit_w; // address in config bank
    logic [7:0] rdata_nxt; // read mux
    logic [23:0] ratio_integer_part; // clocks per period, whole part
    logic [31:0] ratio_fraction_part; // clocks per period, /2^32
    logic [7:0] div_sel_w; // packed channel divider fields
    logic [7:0] status_w; // live status byte

    // reset image, index order
    localparam logic [7:0] RST_IMG [NUM_REG] = '{
        `ORDC_RST_INT_LOW, `ORDC_RST_INT_MID, `ORDC_RST_INT_HIGH,
        `ORDC_RST_FRAC_LOW, `ORDC_RST_FRAC_MA, `ORDC_RST_FRAC_MB,
        `ORDC_RST_FRAC_HIGH, `ORDC_RST_DIV_SEL
    };

    assign idx_w = addr_i - `ORDC_OFF_INT_LOW;
    assign hit_w = (addr_i >= `ORDC_OFF_INT_LOW) && (addr_i <= `ORDC_OFF_DIV_SEL);

    // byte lanes: low first, highest address holds top bits
    assign ratio_integer_part = {cfg_r[2], cfg_r[1], cfg_r[0]};
    assign ratio_fraction_part = {cfg_r[6], cfg_r[5], cfg_r[4], cfg_r[3]};
    assign div_sel_w = cfg_r[7];

    // unmapped addresses read zero
    assign rdata_nxt = hit_w ? cfg_r[idx_w[2:0]] :
                       (addr_i == `ORDC_OFF_STATUS) ? status_w : 8'h00;

    // writes land next edge, reset loads documented image
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NUM_REG; i++) begin
                cfg_r[i] <= RST_IMG[i];
            end
        end else if (wr_i && hit_w) begin
            cfg_r[idx_w[2:0]] <= wdata_i;
        end
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rdata_nxt : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic mode_s1_r; // first stage, read only by second
    logic mode_s2_r; // synced role
    logic strb_s1_r; // first stage, read only by second
    logic strb_s2_r; // synced strobe
    logic strb_s3_r; // previous synced strobe, edge detect
    logic slave_rise_w; // external strobe rising edge

    // two flops before any logic sees a pin
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
            strb_s1_r <= 1'b0;
            strb_s2_r <= 1'b0;
            strb_s3_r <= 1'b0;
        end else begin
            mode_s1_r <= master_mode_i;
            mode_s2_r <= mode_s1_r;
            strb_s1_r <= output_rate_strobe_i;
            strb_s2_r <= strb_s1_r;
            strb_s3_r <= strb_s2_r;
        end
    end

    assign slave_rise_w = strb_s2_r && !strb_s3_r;

    ////////////////////////////////////////////////////////////////////////////
    // fractional rate generator

    logic [23:0] cnt_r; // clocks left in this period
    logic [31:0] acc_r; // fractional remainder
    logic [32:0] acc_sum_w; // remainder plus fraction, carry on top
    logic carry_w; // this period gets one extra clock
    logic [24:0] per_w; // length of next period in clocks
    logic [23:0] cnt_load_w; // reload value, period minus one
    logic gen_tick_w; // generated strobe event
    logic base_tick_w; // strobe event for channel dividers
    logic strobe_r; // strobe pin drive
    logic oe_r; // strobe pin enable

    assign acc_sum_w = {1'b0, acc_r} + {1'b0, ratio_fraction_part};
    assign carry_w = acc_sum_w[32];
    assign per_w = {1'b0, ratio_integer_part} + {24'h0, carry_w};
    // a zero ratio is clamped to one clock per period
    assign cnt_load_w = (per_w == 25'h0) ? 24'h0 : 24'(per_w - 25'h1);
    assign gen_tick_w = mode_s2_r && (cnt_r == 24'h0);
    assign base_tick_w = mode_s2_r ? gen_tick_w : slave_rise_w;

    // ratio writes take effect at the next period start, no glitch mid-period
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 24'h0;
            acc_r <= 32'h0;
        end else if (!mode_s2_r) begin
            // slave: park so master starts with a full period boundary
            cnt_r <= 24'h0;
            acc_r <= 32'h0;
        end else if (gen_tick_w) begin
            cnt_r <= cnt_load_w;
            acc_r <= acc_sum_w[31:0];
        end else begin
            cnt_r <= cnt_r - 24'h1;
        end
    end

    // pin drive only in master role
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strobe_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            strobe_r <= gen_tick_w;
            oe_r <= mode_s2_r;
        end
    end

    assign output_rate_strobe_o = strobe_r;
    assign output_rate_strobe_oe_o = oe_r;
    assign status_w = {6'h0, strb_s2_r, mode_s2_r};

    ////////////////////////////////////////////////////////////////////////////
    // per-channel dividers

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        ordc_div_if div_bus ();
        assign div_bus.tick = base_tick_w;
        assign div_bus.sel = ordc_div_t'(div_sel_w[c*`ORDC_DIV_FIELD_W +: 2]);
        assign ch_strobe_o[c] = div_bus.strobe;
        ordc_chan_div u_div (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .bus(div_bus.div)
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    logic boot_r; // high in first cycle after reset
    logic wr_seen_r; // any write since reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            boot_r <= 1'b1;
            wr_seen_r <= 1'b0;
        end else begin
            boot_r <= 1'b0;
            wr_seen_r <= wr_seen_r || wr_i;
        end
    end

    AST_RESET_IMAGE: assert property (!wr_seen_r |->
        ratio_fraction_part == 32'h2bceb772 && ratio_integer_part == 24'h000040
        && div_sel_w == 8'h00)
        else $error("register reset image wrong");

    AST_INT_MID_WRITE: assert property (wr_i && addr_i == `ORDC_OFF_INT_MID
        |=> ratio_integer_part[15:8] == $past(wdata_i))
        else $error("integer mid byte not written");

    AST_INT_HIGH_READ: assert property (rd_i && addr_i == `ORDC_OFF_INT_HIGH
        |=> rdata_o == ratio_integer_part[23:16])
        else $error("integer high byte read back wrong");

    AST_FRAC_HIGH_WRITE: assert property (wr_i && addr_i == `ORDC_OFF_FRAC_HIGH
        |=> ratio_fraction_part[31:24] == $past(wdata_i))
        else $error("fraction top byte not written");

    AST_SEL_WRITE: assert property (wr_i && addr_i == `ORDC_OFF_DIV_SEL
        |=> div_sel_w[7:6] == $past(wdata_i[7:6]))
        else $error("channel 3 divider field not written");

    AST_PERIOD_WHOLE: assert property (gen_tick_w && !carry_w && ratio_integer_part != 24'h0
        |=> cnt_r == $past(ratio_integer_part) - 24'h1)
        else $error("period length differs from integer ratio");

    AST_PERIOD_CARRY: assert property (gen_tick_w && carry_w
        |=> cnt_r == $past(ratio_integer_part))
        else $error("fraction carry did not stretch period");

    AST_MASTER_STROBE: assert property (gen_tick_w |=> output_rate_strobe_o
        ##1 !output_rate_strobe_o || $past(gen_tick_w))
        else $error("generated strobe not driven");

    AST_SLAVE_NO_DRIVE: assert property (!mode_s2_r |=> !output_rate_strobe_oe_o
        && !output_rate_strobe_o)
        else $error("strobe pin driven in slave role");

    // first cycle out of reset: every output still at its quiet level
    AST_RESET_OUTPUTS: assert property (boot_r |-> rdata_o == 8'h00
        && !output_rate_strobe_o && !output_rate_strobe_oe_o
        && ch_strobe_o == {NUM_CH{1'b0}})
        else $error("outputs not quiet after reset");

endmodule : ordc_top

`default_nettype wire

//--- dv/ordc_host_model.sv
`default_nettype none

module ordc_host_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // host role and its strobe period
    input wire logic drive_i,
    input wire logic [7:0] period_i,
    // device side of the pin
    input wire logic dev_strobe_i,
    input wire logic dev_oe_i,
    // resolved pin level
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_r; // host period count
    logic float_r; // undriven pin wanders, no pull
    wire logic host_pulse = drive_i && (cnt_r == 8'h00);

    ////////////////////////////////////////////////////////////////
    // period counter, one pulse per period_i clocks
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 8'h00;
            float_r <= 1'b0;
        end else begin
            float_r <= ~float_r;
            cnt_r <= (cnt_r + 8'h01 >= period_i) ? 8'h00 : cnt_r + 8'h01;
        end
    end

    // host drives only in slave role, else device or float
    assign pin_o = dev_oe_i ? dev_strobe_i : (drive_i ? host_pulse : float_r);
endmodule : ordc_host_model

`default_nettype wire

//--- dv/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic master = 1'b0;
    logic [7:0] rdata;
    logic pin;
    logic str_o;
    logic oe;
    logic [3:0] ch;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0; // cycle count for periods and timeout
    int n_dev = 0; // device strobe pulses seen
    int n_ch [4] = '{0, 0, 0, 0}; // channel pulses seen
    logic [7:0] ra [8] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d};
    logic [7:0] rv [8] = '{8'h40, 8'h00, 8'h00, 8'h72, 8'hb7, 8'hce, 8'h2b, 8'h00};
    int t0;
    int t1;

    always #12.5 clk = ~clk;

    ordc_top #(.NUM_CH(4)) i_dut (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .master_mode_i(master),
        .output_rate_strobe_i(pin), .output_rate_strobe_o(str_o),
        .output_rate_strobe_oe_o(oe), .ch_strobe_o(ch));

    ordc_host_model i_host (.clk_i(clk), .rst_b_i(rst_b), .drive_i(!master),
        .period_i(8'h05), .dev_strobe_i(str_o), .dev_oe_i(oe), .pin_o(pin));

    ////////////////////////////////////////////////////////////////
    // cycle count and timeout, well above the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end

    // pulse counters, sampled mid-cycle where outputs are settled
    always @(negedge clk) begin
        if (str_o === 1'b1) n_dev++;
        for (int c = 0; c < 4; c++) if (ch[c] === 1'b1) n_ch[c]++;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask : rd_chk

    // cycle number of the next device strobe pulse
    task automatic next_pulse(output int t);
        t = -1;
        for (int k = 0; k < 100 && t < 0; k++) begin
            @(negedge clk);
            if (str_o === 1'b1) t = cyc;
        end
    endtask : next_pulse

    // count pulses over n clocks; ticks base events expected
    task automatic win(input int n, input int ticks, input logic [7:0] sel);
        int d0;
        int s [4];
        wr_reg(8'h1d, sel);
        repeat (12) @(posedge clk);
        d0 = n_dev;
        s = n_ch;
        repeat (n) @(posedge clk);
        chk(n_dev - d0, master ? ticks : 0);
        for (int c = 0; c < 4; c++) chk(n_ch[c] - s[c], ticks >> sel[2*c+:2]);
    endtask : win

    // status role bit only, the pin bit follows live strobes
    task automatic st_chk(input logic exp);
        @(posedge clk);
        addr <= 8'h30;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata & 8'h01, {7'h0, exp});
    endtask : st_chk

    task automatic final_report();
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        // reset values, then write and read back every byte
        for (int i = 0; i < 8; i++) rd_chk(ra[i], rv[i]);
        for (int i = 0; i < 8; i++) wr_reg(ra[i], 8'ha5 ^ i[7:0]);
        for (int i = 0; i < 8; i++) rd_chk(ra[i], 8'ha5 ^ i[7:0]);
        @(negedge clk);
        chk(rdata, 8'h00);
        // unmapped place keeps nothing
        wr_reg(8'h15, 8'hff);
        rd_chk(8'h15, 8'h00);
        // master role, ratio 3 with no fraction
        for (int i = 0; i < 7; i++) wr_reg(ra[i], (i == 0) ? 8'h03 : 8'h00);
        master <= 1'b1;
        repeat (10) @(posedge clk);
        chk(oe, 1'b1);
        st_chk(1'b1);
        next_pulse(t0);
        next_pulse(t1);
        chk(t1 - t0, 3);
        win(96, 32, 8'he4);
        win(96, 32, 8'h1b);
        // half fraction: eight periods average 3.5 clocks
        wr_reg(8'h1c, 8'h80);
        repeat (3) next_pulse(t0);
        repeat (8) next_pulse(t1);
        chk(t1 - t0, 28);
        // slave role: host supplies one strobe per 5 clocks
        @(posedge clk);
        master <= 1'b0;
        repeat (10) @(posedge clk);
        chk(oe, 1'b0);
        st_chk(1'b0);
        win(160, 32, 8'he4);
        final_report();
    end
endmodule : tb

`default_nettype wire
